// ---- common/cms_pkg.sv ----
// cms_pkg: constants, field layout and carrier types of the operating-mode switch
// assumes: one core clock, synchronous active-high reset, 32-bit register port
package cms_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_SEGS = 6;
    localparam int SEG_IDX_W = 3;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_CTL0   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PDBR   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;

    // control_reg_zero fields
    localparam int PE_BIT = 0;
    localparam int PG_BIT = 31;

    // status register fields
    localparam int ST_PE     = 0;
    localparam int ST_PG     = 1;
    localparam int ST_CPL_LO = 2;
    localparam int ST_IF     = 4;
    localparam int ST_PEND   = 5;
    localparam int ST_BUSY   = 6;
    localparam int ST_USE_LO = 8;

    // reset values
    localparam logic [DATA_W-1:0] CTL0_RST      = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PDBR_RST      = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PDBR_FLUSH    = 32'h0000_0000;
    localparam logic [31:0]       RESET_CS_BASE = 32'hFFFF_0000;
    localparam logic [31:0]       RESET_IP      = 32'h0000_FF00;
    localparam logic [15:0]       RESET_CS_SEL  = 16'hF000;
    localparam logic [31:0]       REAL_LIMIT    = 32'h0000_FFFF;
    localparam logic [7:0]        REAL_CODE_ATTR = 8'h9B;
    localparam logic [7:0]        REAL_DATA_ATTR = 8'h93;
    localparam logic [1:0]        CPL_TOP       = 2'h0;

    // segment register slots
    localparam logic [SEG_IDX_W-1:0] SEG_ES = 3'h0;
    localparam logic [SEG_IDX_W-1:0] SEG_CS = 3'h1;
    localparam logic [SEG_IDX_W-1:0] SEG_SS = 3'h2;
    localparam logic [SEG_IDX_W-1:0] SEG_DS = 3'h3;
    localparam logic [SEG_IDX_W-1:0] SEG_FS = 3'h4;
    localparam logic [SEG_IDX_W-1:0] SEG_GS = 3'h5;

    // selector plus hidden descriptor part of one segment register
    typedef struct packed {
        logic [15:0] sel;
        logic [31:0] base;
        logic [31:0] limit;
        logic [7:0]  attr;
    } cms_seg_t;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } cms_bus_req_t;

    // segment load or far transfer from the instruction unit
    typedef struct packed {
        logic                 valid;
        logic                 is_far;
        logic [SEG_IDX_W-1:0] idx;
        cms_seg_t             seg;
        logic [31:0]          ip;
    } cms_load_req_t;

endpackage : cms_pkg

// ---- hdl/cms_sync2.sv ----
// cms_sync2: two-flop synchroniser for asynchronous pin levels
// assumes: inputs come from pins outside the core clock domain
`timescale 1ns/1ps
module cms_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } cms_sync_st_t;

    cms_sync_st_t s_q;
    cms_sync_st_t s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_q = s_q.sync;
endmodule : cms_sync2

// ---- hdl/cms_seg_mem.sv ----
// cms_seg_mem: segment register file, one entry per segment register
// assumes: one writer; both read ports answer one cycle after the index
`timescale 1ns/1ps
module cms_seg_mem #(
    parameter int DEPTH = cms_pkg::NUM_SEGS,
    parameter int IDX_W = cms_pkg::SEG_IDX_W
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [IDX_W-1:0] rd_a_idx,
    input  wire logic [IDX_W-1:0] rd_b_idx,
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  cms_pkg::cms_seg_t     wr_data,
    output cms_pkg::cms_seg_t     rd_a_q,
    output cms_pkg::cms_seg_t     rd_b_q
);
    typedef struct packed {
        cms_pkg::cms_seg_t [DEPTH-1:0] mem;
        cms_pkg::cms_seg_t             rd_a;
        cms_pkg::cms_seg_t             rd_b;
    } cms_mem_st_t;

    cms_mem_st_t s_q;
    cms_mem_st_t s_d;

    // reset contents: real-mode segments at base 0, code segment at the top
    function automatic cms_pkg::cms_seg_t rst_entry(input int i);
        cms_pkg::cms_seg_t e;
        e.sel   = 16'h0000;
        e.base  = 32'h0000_0000;
        e.limit = cms_pkg::REAL_LIMIT;
        e.attr  = cms_pkg::REAL_DATA_ATTR;
        if (i == int'(cms_pkg::SEG_CS)) begin
            e.sel  = cms_pkg::RESET_CS_SEL;
            e.base = cms_pkg::RESET_CS_BASE;
            e.attr = cms_pkg::REAL_CODE_ATTR;
        end
        return e;
    endfunction : rst_entry

    // out-of-range index reads as the first entry rather than X
    always_comb begin
        s_d      = s_q;
        s_d.rd_a = (int'(rd_a_idx) < DEPTH) ? s_q.mem[rd_a_idx] : s_q.mem[0];
        s_d.rd_b = (int'(rd_b_idx) < DEPTH) ? s_q.mem[rd_b_idx] : s_q.mem[0];
        if (wr_en && (int'(wr_idx) < DEPTH)) begin
            s_d.mem[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                s_q.mem[i] <= rst_entry(i);
            end
            s_q.rd_a <= '0;
            s_q.rd_b <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_a_q = s_q.rd_a;
    assign rd_b_q = s_q.rd_b;
endmodule : cms_seg_mem

// ---- hdl/cms_mode_ctl.sv ----
// cms_mode_ctl: real/protected operating-mode switch of the core
// assumes: register port and load requests come from core logic on ref_clk;
// interrupt pins are asynchronous and are synchronised here
`timescale 1ns/1ps
module cms_mode_ctl (
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    input  cms_pkg::cms_bus_req_t              bus_req,
    output logic [cms_pkg::DATA_W-1:0]         bus_rdata_q,
    input  cms_pkg::cms_load_req_t             load_req,
    input  wire logic [cms_pkg::SEG_IDX_W-1:0] seg_rd_idx,
    output cms_pkg::cms_seg_t                  seg_rd_q,
    input  wire logic                          irq_enable_insn,
    input  wire logic                          irq_disable_insn,
    input  wire logic                          maskable_irq_in,
    input  wire logic                          nmi_in,
    output logic                               protected_mode_q,
    output logic                               paging_on_q,
    output logic [1:0]                         current_privilege_level_q,
    output logic [31:0]                        cs_base_q,
    output logic [31:0]                        fetch_addr_q,
    output logic                               flush_q,
    output logic                               tlb_flush_q,
    output logic                               seg_busy_q,
    output logic                               irq_req_q,
    output logic                               nmi_req_q
);
    typedef enum logic [1:0] {
        CMS_IDLE,
        CMS_READ,
        CMS_MERGE
    } cms_fsm_t;

    typedef struct packed {
        logic [31:0]                 ctl0;
        logic [31:0]                 pdbr;
        logic [1:0]                  current_privilege_level;
        logic                        if_en;
        logic [cms_pkg::NUM_SEGS-1:0] usable;
        logic [31:0]                 cs_base;
        logic [31:0]                 fetch_addr;
        logic                        flush;
        logic                        tlb_flush;
        logic                        pend;
        logic [31:0]                 rdata;
        logic                        prot;
        logic                        paging;
        logic                        irq_req;
        logic                        nmi_req;
        cms_fsm_t                    fsm;
        cms_pkg::cms_load_req_t      req;
    } cms_mode_st_t;

    cms_mode_st_t      s_q;
    cms_mode_st_t      s_d;
    logic [1:0]        pins_sync;
    cms_pkg::cms_seg_t old_entry;
    cms_pkg::cms_seg_t new_entry;
    logic              mem_wr;

    // interrupt pins arrive from outside the core clock
    cms_sync2 #(
        .WIDTH (2)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({nmi_in, maskable_irq_in}),
        .sync_q   (pins_sync)
    );

    // port a serves the read-modify-write of a load, port b the core's lookups
    cms_seg_mem #(
        .DEPTH (cms_pkg::NUM_SEGS),
        .IDX_W (cms_pkg::SEG_IDX_W)
    ) u_seg_mem (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .rd_a_idx (s_q.req.idx),
        .rd_b_idx (seg_rd_idx),
        .wr_en    (mem_wr),
        .wr_idx   (s_q.req.idx),
        .wr_data  (new_entry),
        .rd_a_q   (old_entry),
        .rd_b_q   (seg_rd_q)
    );

    // a selector with index and table bits all zero is the null selector
    function automatic logic is_null(input logic [15:0] sel);
        return (sel[15:2] == 14'h0000);
    endfunction : is_null

    // real-mode base is the selector shifted by four
    function automatic logic [31:0] real_base(input logic [15:0] sel);
        return {12'h000, sel, 4'h0};
    endfunction : real_base

    // new contents of one segment register from its old entry and the request
    function automatic cms_pkg::cms_seg_t merge_entry(
        input cms_pkg::cms_seg_t      old_e,
        input cms_pkg::cms_load_req_t r,
        input logic                   prot
    );
        cms_pkg::cms_seg_t e;
        e = old_e;
        if (prot) begin
            e = r.seg;
        end else begin
            // real-mode load keeps the limit left from protected mode, and the rights unless it is a far transfer
            e.sel  = r.seg.sel;
            e.base = real_base(r.seg.sel);
            if (r.is_far) begin
                e.attr = cms_pkg::REAL_CODE_ATTR;
            end
        end
        return e;
    endfunction : merge_entry

    assign mem_wr    = (s_q.fsm == CMS_MERGE);
    assign new_entry = merge_entry(old_entry, s_q.req, s_q.prot);

    // next state of the whole block
    always_comb begin
        logic [31:0] wval;
        logic        pe_new;
        wval        = bus_req.wdata;
        pe_new      = wval[cms_pkg::PE_BIT];
        s_d         = s_q;
        s_d.flush     = 1'b0;
        s_d.tlb_flush = 1'b0;
        s_d.rdata     = '0;

        // register writes; ctl0 is stored whole so it reads back as written
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                cms_pkg::OFF_CTL0: begin
                    s_d.ctl0 = wval;
                    if (!s_q.prot && pe_new) begin
                        s_d.prot = 1'b1;
                        s_d.current_privilege_level  = cms_pkg::CPL_TOP;
                        s_d.pend = 1'b1;
                    end else if (s_q.prot && !pe_new) begin
                        s_d.prot = 1'b0;
                        s_d.current_privilege_level  = cms_pkg::CPL_TOP;
                        s_d.pend = 1'b1;
                    end
                    // paging only takes effect together with protection
                    s_d.paging = pe_new && wval[cms_pkg::PG_BIT];
                end
                cms_pkg::OFF_PDBR: begin
                    s_d.pdbr = wval;
                    if (wval == cms_pkg::PDBR_FLUSH) begin
                        s_d.tlb_flush = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads answer in the next cycle; unmapped reads give zero
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                cms_pkg::OFF_CTL0: begin
                    s_d.rdata = s_q.ctl0;
                end
                cms_pkg::OFF_PDBR: begin
                    s_d.rdata = s_q.pdbr;
                end
                cms_pkg::OFF_STATUS: begin
                    s_d.rdata[cms_pkg::ST_PE]                = s_q.prot;
                    s_d.rdata[cms_pkg::ST_PG]                = s_q.paging;
                    s_d.rdata[cms_pkg::ST_CPL_LO +: 2]       = s_q.current_privilege_level;
                    s_d.rdata[cms_pkg::ST_IF]                = s_q.if_en;
                    s_d.rdata[cms_pkg::ST_PEND]              = s_q.pend;
                    s_d.rdata[cms_pkg::ST_BUSY]              = (s_q.fsm != CMS_IDLE);
                    s_d.rdata[cms_pkg::ST_USE_LO +: cms_pkg::NUM_SEGS] = s_q.usable;
                end
                default: begin
                end
            endcase
        end

        // segment loads: the write of ctl0 above never touches the segment file,
        // so every register keeps what it held until software reloads it
        unique case (s_q.fsm)
            CMS_IDLE: begin
                if (load_req.valid) begin
                    s_d.req = load_req;
                    s_d.fsm = CMS_READ;
                end
            end
            CMS_READ: begin
                // memory samples the index this cycle, entry is ready next
                s_d.fsm = CMS_MERGE;
            end
            CMS_MERGE: begin
                s_d.fsm = CMS_IDLE;
                if (s_q.prot && !s_q.req.is_far && is_null(s_q.req.seg.sel)) begin
                    s_d.usable[s_q.req.idx] = 1'b0;
                end else begin
                    s_d.usable[s_q.req.idx] = 1'b1;
                end
                if (s_q.req.is_far) begin
                    // far transfer: new code base, queue discarded in the same cycle
                    s_d.usable[cms_pkg::SEG_CS] = 1'b1;
                    s_d.cs_base    = new_entry.base;
                    s_d.fetch_addr = new_entry.base + s_q.req.ip;
                    s_d.flush      = 1'b1;
                    // a mode write landing in this same cycle re-arms the flag: set wins
                    s_d.pend       = s_d.pend && (s_d.prot != s_q.prot);
                    s_d.current_privilege_level        = s_q.prot ? s_q.req.seg.sel[1:0] : cms_pkg::CPL_TOP;
                end
            end
        endcase

        // maskable enable; disable wins if both arrive together
        if (irq_disable_insn) begin
            s_d.if_en = 1'b0;
        end else if (irq_enable_insn) begin
            s_d.if_en = 1'b1;
        end
        s_d.irq_req = pins_sync[0] && s_q.if_en;
        // non-maskable input is never gated here; the board holds it off
        s_d.nmi_req = pins_sync[1];
    end

    // one register for all state; reset puts the core in real mode at the top
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q            <= '0;
            s_q.ctl0       <= cms_pkg::CTL0_RST;
            s_q.pdbr       <= cms_pkg::PDBR_RST;
            s_q.current_privilege_level        <= cms_pkg::CPL_TOP;
            s_q.if_en      <= 1'b0;
            s_q.usable     <= '1;
            s_q.cs_base    <= cms_pkg::RESET_CS_BASE;
            s_q.fetch_addr <= cms_pkg::RESET_CS_BASE + cms_pkg::RESET_IP;
            s_q.prot       <= 1'b0;
            s_q.paging     <= 1'b0;
            s_q.fsm        <= CMS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // every output here is a flop of the state record, except seg_busy_q which decodes fsm
    assign bus_rdata_q               = s_q.rdata;
    assign protected_mode_q          = s_q.prot;
    assign paging_on_q               = s_q.paging;
    assign current_privilege_level_q = s_q.current_privilege_level;
    assign cs_base_q                 = s_q.cs_base;
    assign fetch_addr_q              = s_q.fetch_addr;
    assign flush_q                   = s_q.flush;
    assign tlb_flush_q               = s_q.tlb_flush;
    assign seg_busy_q                = (s_q.fsm != CMS_IDLE);
    assign irq_req_q                 = s_q.irq_req;
    assign nmi_req_q                 = s_q.nmi_req;
endmodule : cms_mode_ctl

// ---- sim/cms_mode_ctl_properties.sv ----
// cms_mode_ctl_properties: port-level timing checks of the mode switch
// assumes: bound into cms_mode_ctl; one clock, sync active-high reset
`timescale 1ns/1ps
module cms_mode_ctl_properties (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  cms_pkg::cms_bus_req_t  bus_req,
    input  cms_pkg::cms_load_req_t load_req,
    input  wire logic              nmi_in,
    input  wire logic              protected_mode_q,
    input  wire logic              paging_on_q,
    input  wire logic [1:0]        current_privilege_level_q,
    input  wire logic [31:0]       cs_base_q,
    input  wire logic [31:0]       fetch_addr_q,
    input  wire logic              flush_q,
    input  wire logic              tlb_flush_q,
    input  wire logic              seg_busy_q,
    input  wire logic              irq_req_q,
    input  wire logic              nmi_req_q
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // busy excluded so a far commit cannot race the mode write
    wire ctl_wr = bus_req.wr && bus_req.addr == cms_pkg::OFF_CTL0 && !seg_busy_q;
    wire pdbr_zero = bus_req.wr && bus_req.addr == cms_pkg::OFF_PDBR
                     && bus_req.wdata == cms_pkg::PDBR_FLUSH;
    // far transfer: taken, two busy cycles, then commit with the flush pulse
    sequence far_take;
        load_req.valid && load_req.is_far && !seg_busy_q;
    endsequence
    sequence far_commit;
        seg_busy_q [*2] ##1 (!seg_busy_q && flush_q);
    endsequence
    chk_pe_enter: assert property (ctl_wr && bus_req.wdata[0] && !protected_mode_q
        |=> protected_mode_q && current_privilege_level_q == cms_pkg::CPL_TOP)
        else $error("mode or privilege wrong after enable write");
    chk_pg_same: assert property (ctl_wr && bus_req.wdata[0] && bus_req.wdata[31]
        |=> paging_on_q) else $error("paging not on after combined write");
    chk_pe_leave: assert property (ctl_wr && !bus_req.wdata[0]
        |=> !protected_mode_q && !paging_on_q) else $error("real mode not restored");
    chk_tlb_zero: assert property (pdbr_zero |=> tlb_flush_q)
        else $error("no translation flush after zero write");
    chk_tlb_cause: assert property (tlb_flush_q |-> $past(pdbr_zero))
        else $error("translation flush without zero write");
    chk_far_flush: assert property (far_take |=> far_commit)
        else $error("far transfer did not flush on time");
    chk_flush_cause: assert property (flush_q |-> $past(seg_busy_q) && !seg_busy_q)
        else $error("flush pulse outside a load commit");
    chk_cs_hold: assert property (!flush_q |-> $stable(cs_base_q)
        && $stable(fetch_addr_q)) else $error("code base moved without far transfer");
    chk_reset_start: assert property ($fell(reset) |-> !paging_on_q && !irq_req_q
        && fetch_addr_q == cms_pkg::RESET_CS_BASE + cms_pkg::RESET_IP
        && cs_base_q == cms_pkg::RESET_CS_BASE) else $error("bad state after reset");
    chk_nmi_open: assert property (nmi_in [*4] |-> nmi_req_q)
        else $error("non-maskable input not passed through");
endmodule : cms_mode_ctl_properties

bind cms_mode_ctl cms_mode_ctl_properties i_chk (
    .ref_clk, .reset, .bus_req, .load_req, .nmi_in, .protected_mode_q, .paging_on_q,
    .current_privilege_level_q, .cs_base_q, .fetch_addr_q, .flush_q, .tlb_flush_q,
    .seg_busy_q, .irq_req_q, .nmi_req_q
);

// ---- sim/cms_sw_model.sv ----
// cms_sw_model: initialization software issuing segment loads and far transfers
// assumes: drives load_req of cms_mode_ctl on ref_clk and honours seg_busy_q
`timescale 1ns/1ps
module cms_sw_model (
    input  wire logic              ref_clk,
    input  wire logic              seg_busy_q,
    output cms_pkg::cms_load_req_t load_req
);
    initial begin
        load_req = '0;
    end
    // one load; gap idles first so the model answers promptly or slowly
    // targets stay in identity-mapped code, linear equal to physical
    task automatic seg_load(input int gap, input logic far, input logic [2:0] idx,
                            input cms_pkg::cms_seg_t seg, input logic [31:0] ip);
        cms_pkg::cms_load_req_t r;
        cms_pkg::cms_load_req_t idle_v;
        r = '{1'b1, far, idx, seg, ip};
        idle_v = ~r;
        idle_v.valid = 1'b0;
        // a request while busy would be dropped, so wait for the file to be free
        while (seg_busy_q) begin
            @(posedge ref_clk);
            #1;
        end
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        load_req <= r;
        // stale fields are inverted, never left looking valid
        @(posedge ref_clk);
        load_req <= idle_v;
        // fixed two busy cycles, then commit is visible
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : seg_load
endmodule : cms_sw_model

// ---- sim/test_cpu_operating_mode_switch.sv ----
// test_cpu_operating_mode_switch: directed checks of the real/protected mode switch
// assumes: cms_mode_ctl as dut, cms_sw_model on the load port, checker bound in
`timescale 1ns/1ps
module test_cpu_operating_mode_switch;
    logic                   ref_clk;
    logic                   reset;
    cms_pkg::cms_bus_req_t  bus_req;
    logic [31:0]            bus_rdata_q;
    cms_pkg::cms_load_req_t load_req;
    logic [2:0]             seg_rd_idx;
    cms_pkg::cms_seg_t      seg_rd_q;
    logic                   irq_enable_insn;
    logic                   irq_disable_insn;
    logic                   maskable_irq_in;
    logic                   nmi_in;
    logic                   protected_mode_q;
    logic                   paging_on_q;
    logic [1:0]             current_privilege_level_q;
    logic [31:0]            cs_base_q;
    logic [31:0]            fetch_addr_q;
    logic                   flush_q;
    logic                   tlb_flush_q;
    logic                   seg_busy_q;
    logic                   irq_req_q;
    logic                   nmi_req_q;
    int                     err_count;
    int                     checked;
    int                     cycles = 0;

    cms_mode_ctl i_dut (
        .ref_clk, .reset, .bus_req, .bus_rdata_q, .load_req, .seg_rd_idx, .seg_rd_q,
        .irq_enable_insn, .irq_disable_insn, .maskable_irq_in, .nmi_in, .protected_mode_q,
        .paging_on_q, .current_privilege_level_q, .cs_base_q, .fetch_addr_q, .flush_q,
        .tlb_flush_q, .seg_busy_q, .irq_req_q, .nmi_req_q
    );
    cms_sw_model i_sw (.ref_clk, .seg_busy_q, .load_req);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // hang guard: the directed run needs well under this many cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic check(input logic [87:0] got, input logic [87:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // single-cycle write; address and data are scrambled once released
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req <= '{~a, ~d, 1'b0, 1'b0};
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req <= '{~a, 32'hFFFF_FFFF, 1'b0, 1'b0};
        #1;
        check(bus_rdata_q, exp);
    endtask : rd_reg
    task automatic seg_look(input logic [2:0] idx, input cms_pkg::cms_seg_t exp);
        @(posedge ref_clk);
        seg_rd_idx <= idx;
        @(posedge ref_clk);
        #1;
        check(seg_rd_q, exp);
    endtask : seg_look
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        err_count = 0;
        checked = 0;
        reset = 1'b1;
        bus_req = '0;
        seg_rd_idx = 3'h0;
        irq_enable_insn = 1'b0;
        irq_disable_insn = 1'b0;
        maskable_irq_in = 1'b1;
        nmi_in = 1'b0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        check(fetch_addr_q, 32'hFFFF_FF00);
        rd_reg(cms_pkg::OFF_STATUS, 32'h0000_3F00);
        rd_reg(8'h0C, 32'h0000_0000);
        check(irq_req_q, 1'b0);
        // interrupts off, then paging base, then enter with paging
        @(posedge ref_clk);
        irq_disable_insn <= 1'b1;
        @(posedge ref_clk);
        irq_disable_insn <= 1'b0;
        wr_reg(cms_pkg::OFF_PDBR, 32'h0001_0000);
        check(tlb_flush_q, 1'b0);
        wr_reg(cms_pkg::OFF_CTL0, 32'h8000_0001);
        check({protected_mode_q, paging_on_q, current_privilege_level_q}, 4'hC);
        check(cs_base_q, cms_pkg::RESET_CS_BASE);
        rd_reg(cms_pkg::OFF_CTL0, 32'h8000_0001);
        rd_reg(cms_pkg::OFF_STATUS, 32'h0000_3F23);
        i_sw.seg_load(0, 1'b1, cms_pkg::SEG_CS, '{16'h0013, 32'h0010_0000, 32'hFFFF, 8'h9B},
                      32'h20);
        check({flush_q, current_privilege_level_q, fetch_addr_q}, {3'h7, 32'h0010_0020});
        check(cs_base_q, 32'h0010_0000);
        i_sw.seg_load(3, 1'b0, cms_pkg::SEG_DS, '{16'h0000, 32'h0, 32'hFFFF, 8'h93}, 32'h0);
        check(flush_q, 1'b0);
        rd_reg(cms_pkg::OFF_STATUS, 32'h0000_370F);
        seg_look(cms_pkg::SEG_ES, '{16'h0000, 32'h0, 32'hFFFF, 8'h93});
        i_sw.seg_load(0, 1'b0, cms_pkg::SEG_SS, '{16'h0010, 32'h0002_0000, 32'hFFFF, 8'h93},
                      32'h0);
        // interrupt table lives outside this block and already sits below 1 MByte
        // leave: paging off, zero the base, then clear protect enable
        wr_reg(cms_pkg::OFF_CTL0, 32'h0000_0001);
        check({protected_mode_q, paging_on_q}, 2'h2);
        wr_reg(cms_pkg::OFF_PDBR, 32'h0000_0000);
        check(tlb_flush_q, 1'b1);
        wr_reg(cms_pkg::OFF_CTL0, 32'h0000_0000);
        check({protected_mode_q, paging_on_q}, 2'h0);
        i_sw.seg_load(1, 1'b1, cms_pkg::SEG_CS, '{16'h1234, 32'h0, 32'h0, 8'h00}, 32'h10);
        check({flush_q, cs_base_q, fetch_addr_q}, {1'b1, 32'h0001_2340, 32'h0001_2350});
        seg_look(cms_pkg::SEG_CS, '{16'h1234, 32'h0001_2340, 32'hFFFF, 8'h9B});
        seg_look(cms_pkg::SEG_SS, '{16'h0010, 32'h0002_0000, 32'hFFFF, 8'h93});
        rd_reg(cms_pkg::OFF_STATUS, 32'h0000_3700);
        // interrupts back on; non-maskable input now unblocked
        @(posedge ref_clk);
        irq_enable_insn <= 1'b1;
        nmi_in <= 1'b1;
        @(posedge ref_clk);
        irq_enable_insn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check({irq_req_q, nmi_req_q}, 2'h3);
        finish_test();
    end
endmodule : test_cpu_operating_mode_switch
